/* bell_relay_ctrl.sv */
// Purpose: Two bell outputs with supervision and one auxiliary relay.
// Assumes: Panel inputs are on core_clk; loop and AC pins are not.
// Notes:   Registers over AXI4-Lite; all timing on a half-second tick.
// Contract
// [RULE1] Default: first bell unsupervised burglary, second supervised fire.
// [RULE2] Supervision active when its zone holds code 19; faults raise trouble.
// [RULE3] Supervision zone code zero reports no wiring faults.
// [RULE4] Fire bell detects open, short and earth-ground faults.
// [RULE5] Default first bell steady for zones three to eight, 16 minutes.
// [RULE6] Default second bell pulsed for zones one and two, no timeout.
// [RULE7] A bell without assigned zones stays silent for alarms.
// [RULE8] Fire-silenced shown when bell has no zones or is unsupervised.
// [RULE9] Per-bell pulse, timeout, ding and chime; shared temporal pattern.
// [RULE10] Tamper enable makes zone six a bell-housing tamper input.
// [RULE11] Relay runs one function picked by a programmed code.
// [RULE12] Code 1: steady on alarm until timeout or code plus OFF.
// [RULE13] Code 4: latched on alarm until code plus # 67.
// [RULE14] Default relay: code 1, zones one to eight, no timeout.
// [RULE15] Code 1: brief pulse for arming and chime when enabled.
// [RULE16] Code 0: on for troubles; off after faults clear and OFF.
// [RULE17] Code 2: six-second pulse on second code plus OFF.
// [RULE18] Code 3: normally on, off four hours into AC failure.
// [RULE19] Battery saver re-energises a few seconds after AC returns.
// [RULE20] Bell timeout is none or two to thirty minutes.
// [RULE21] Arming ding sounds the bell one to two seconds.
// [RULE22] AC return before four hours cancels and restarts the interval.
// [RULE23] Pulsed bell cadences; stops on timeout or silence.
`include "bell_relay_params.svh"
`timescale 1ns/1ps
`default_nettype none

module bell_relay_ctrl #(
  parameter int HALF_CYCLES  = `HALF_CYC,
  parameter int BSAVE_HALVES = `BSAVE_HALVES
) (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // AXI4-Lite slave.
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Panel events on core_clk.
  input  wire logic [7:0]                zone_alarm,
  input  wire logic                      user_off,
  input  wire logic                      user_67,
  input  wire logic                      system_armed,
  input  wire logic                      chime_fault,
  input  wire logic                      chime_mode,
  input  wire logic                      fire_alarm,
  input  wire logic                      trouble_any,
  input  wire logic                      fire_supervisory,
  // Asynchronous pins.
  input  wire logic                      ac_fail,
  input  wire logic                      first_bell_supervision_jumper,
  input  wire logic                      second_bell_supervision_jumper,
  input  wire bell_pkg::wire_fault_s [1:0] bell_fault,
  // Outputs.
  output wire logic [1:0]                bell_drive,
  output wire logic [1:0]                bell_trouble,
  output var  logic                      fire_silenced,
  output var  logic                      bell_tamper,
  output var  logic                      aux_relay
);

  localparam int DW = $clog2(HALF_CYCLES);
  localparam logic [14:0] BSAVE_N = 15'(BSAVE_HALVES);

  // Refuse settings the counters cannot hold.
  if (HALF_CYCLES < 2 || BSAVE_HALVES < 1 || BSAVE_HALVES > 32767) begin : g_chk
    $error("bell_relay_ctrl: parameter out of range");
  end

  // Timeout minutes to half ticks; out-of-range codes are clamped.
  function automatic logic [11:0] tmo_halves(input logic [4:0] m);
    logic [4:0] c;
    c = m;
    if (m != 5'h00 && m < `TMO_MIN) c = `TMO_MIN;
    if (m > `TMO_MAX) c = `TMO_MAX;
    return 12'(c) * 12'(`MIN_HALVES);
  endfunction

  // Byte-lane merge of a write into a register.
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s,
                                        input logic [31:0] m);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r & m;
  endfunction

  logic [31:0] bell_cfg_ff, bell_tmo_ff, zones_ff, sup_ff, relay_ff;
  logic [8:0]  meta_ff, sync_ff;
  logic [DW-1:0] div_ff;
  logic        half_ff;
  logic [2:0]  ph_ff;
  logic        ac_s, pulse_on;
  logic [1:0]  jmp_s;
  bell_pkg::wire_fault_s [1:0] fault_s;
  logic [7:0]  tamp_excl;
  wire  [1:0]  drv_w, trb_w, quiet_w;

  // Two-stage synchroniser; only the second stage is read.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 9'h000;
      sync_ff <= 9'h000;
    end else begin
      meta_ff <= {ac_fail, second_bell_supervision_jumper,
                  first_bell_supervision_jumper, bell_fault};
      sync_ff <= meta_ff;
    end
  end
  assign fault_s = sync_ff[5:0];
  assign jmp_s   = sync_ff[7:6];
  assign ac_s    = sync_ff[8];

  // Half-second tick divider drives every slow count.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff  <= '0;
      half_ff <= 1'b0;
    end else if (div_ff == DW'(HALF_CYCLES - 1)) begin
      div_ff  <= '0;
      half_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + DW'(1);
      half_ff <= 1'b0;
    end
  end

  // Free-running cadence phase shared by both bells.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 3'h0;
    end else if (half_ff) begin
      ph_ff <= ph_ff + 3'h1;
    end
  end
  // Temporal: three half-second beats, then a long gap.
  assign pulse_on = bell_cfg_ff[`BC_TEMPORAL] ?
                    (!ph_ff[0] && ph_ff < 3'h6) : !ph_ff[0]; // RULE9 RULE23

  // Zone six is kept out of alarm masks while it serves as tamper.
  assign tamp_excl = bell_cfg_ff[`BC_TAMPER] ? 8'h20 : 8'h00; // RULE10
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bell_tamper <= 1'b0;
    end else begin
      bell_tamper <= bell_cfg_ff[`BC_TAMPER] && zone_alarm[5]; // RULE10
    end
  end

  // Per-bell alarm latch, timeout, ding, chime and supervision.
  for (genvar i = 0; i < 2; i++) begin : g_bell
    logic [7:0]  mask;
    logic [11:0] lim;
    logic        hit, sup_on, flt;
    logic        hit_q, act_q, drv_q, trb_q;
    logic [11:0] tc_q;
    logic [1:0]  dg_q;
    assign mask   = zones_ff[i*8 +: 8] & ~tamp_excl;
    assign hit    = |(zone_alarm & mask); // RULE7
    assign lim    = tmo_halves(bell_tmo_ff[i*8 +: 5]); // RULE20
    assign sup_on = sup_ff[i*8 +: 8] == `SUP_CODE && jmp_s[i]; // RULE2
    assign flt    = |fault_s[i]; // RULE4

    // A fresh alarm restarts the latch; it wins over a silence.
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        hit_q <= 1'b0;
        act_q <= 1'b0;
        tc_q  <= 12'h000;
      end else begin
        hit_q <= hit;
        if (hit && !hit_q) begin
          act_q <= 1'b1; // RULE5 RULE6
          tc_q  <= 12'h000;
        end else if (user_off || (lim != 12'h000 && tc_q >= lim)) begin
          act_q <= 1'b0; // RULE23
        end else if (act_q && half_ff) begin
          tc_q <= tc_q + 12'h001;
        end
      end
    end

    // Ding on arming and chime share one short countdown.
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        dg_q <= 2'h0;
      end else if (system_armed && bell_cfg_ff[i*4 + `BC_DING]) begin
        dg_q <= 2'(`DING_HALVES); // RULE21
      end else if (chime_fault && chime_mode &&
                   bell_cfg_ff[i*4 + `BC_CHIME]) begin
        dg_q <= 2'(`CHIME_HALVES); // RULE9
      end else if (half_ff && dg_q != 2'h0) begin
        dg_q <= dg_q - 2'h1;
      end
    end

    // Drive and trouble flops feed the pins directly.
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        drv_q <= 1'b0;
        trb_q <= 1'b0;
      end else begin
        drv_q <= act_q ? (!bell_cfg_ff[i*4 + `BC_PULSE] || pulse_on)
                       : (dg_q != 2'h0); // RULE9
        trb_q <= sup_on && flt; // RULE2 RULE3 RULE4
      end
    end
    assign drv_w[i]   = drv_q;
    assign trb_w[i]   = trb_q;
    assign quiet_w[i] = zones_ff[i*8 +: 8] == 8'h00 || !sup_on;

    a_sup_off_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      sup_ff[i*8 +: 8] == `SUP_NONE |=> !trb_q) // RULE3
      else $error("trouble raised with supervision off");
    a_fault_trouble: assert property (@(posedge core_clk) disable iff (!rst_n)
      sup_on && flt ##1 sup_on && flt |-> trb_q) // RULE2
      else $error("wiring fault not reported");
    a_zone_needed: assert property (@(posedge core_clk) disable iff (!rst_n)
      zones_ff[i*8 +: 8] == 8'h00 && !act_q |=> !act_q) // RULE7
      else $error("bell latched with no zones");
    a_bell_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
      act_q && lim != 12'h000 && tc_q >= lim && !(hit && !hit_q)
      |=> !act_q ##1 (!drv_q || $past(dg_q) != 2'h0)) // RULE23
      else $error("bell kept sounding after timeout");
  end
  assign bell_drive   = drv_w;
  assign bell_trouble = trb_w;

  // No supervised, assigned bell can carry the fire alarm.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fire_silenced <= 1'b0;
    end else begin
      fire_silenced <= fire_alarm && (&quiet_w); // RULE8
    end
  end

  a_silenced_ind: assert property (@(posedge core_clk) disable iff (!rst_n)
    fire_alarm && (&quiet_w) |=> fire_silenced) // RULE8
    else $error("fire silenced indication missing");

  // Relay decode.
  bell_pkg::relay_fn_e fn;
  logic [7:0]  rmask;
  logic [11:0] rlim, rt_ff;
  logic        rhit, rhit_ff, rnew, rfault, rset, rclr, rlat_ff, rout;
  logic [1:0]  rp_ff;
  logic        off_seen_ff;
  logic [3:0]  sm_ff;
  logic [14:0] fc_ff;
  logic [2:0]  oc_ff;
  logic        bs_ff;
  assign fn     = bell_pkg::relay_fn_e'(relay_ff[2:0]); // RULE11
  assign rmask  = relay_ff[23:16] & ~tamp_excl;
  assign rhit   = |(zone_alarm & rmask);
  assign rnew   = rhit && !rhit_ff;
  assign rlim   = tmo_halves(relay_ff[12:8]);
  assign rfault = trouble_any || fire_supervisory || (|trb_w);

  // Set and clear of the relay latch per function.
  always_comb begin
    rset = 1'b0;
    rclr = 1'b0;
    unique case (fn)
      bell_pkg::FN_TROUBLE: begin
        rset = rfault; // RULE16
        rclr = user_off && !rfault;
      end
      bell_pkg::FN_ALARM: begin
        rset = rnew; // RULE12
        rclr = user_off || (rlim != 12'h000 && rt_ff >= rlim);
      end
      bell_pkg::FN_LATCH: begin
        rset = rnew; // RULE13
        rclr = user_67;
      end
      default: rclr = 1'b1;
    endcase
  end

  // Relay latch and its timeout; a set beats a clear.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rhit_ff <= 1'b0;
      rlat_ff <= 1'b0;
      rt_ff   <= 12'h000;
    end else begin
      rhit_ff <= rhit;
      if (rset) begin
        rlat_ff <= 1'b1;
        if (rnew) rt_ff <= 12'h000;
      end else if (rclr) begin
        rlat_ff <= 1'b0;
      end else if (rlat_ff && half_ff) begin
        rt_ff <= rt_ff + 12'h001;
      end
    end
  end

  // Brief arming and chime pulse in alarm function.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_ff <= 2'h0;
    end else if (fn == bell_pkg::FN_ALARM &&
                 ((system_armed && relay_ff[`RC_DING]) ||
                  (chime_fault && chime_mode && relay_ff[`RC_CHIME]))) begin
      rp_ff <= 2'(`CHIME_HALVES) + 2'h1; // RULE15
    end else if (half_ff && rp_ff != 2'h0) begin
      rp_ff <= rp_ff - 2'h1;
    end
  end

  // Smoke reset: every second OFF entry opens power for six seconds.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      off_seen_ff <= 1'b0;
      sm_ff       <= 4'h0;
    end else if (fn != bell_pkg::FN_SMOKE) begin
      off_seen_ff <= 1'b0;
      sm_ff       <= 4'h0;
    end else if (user_off) begin
      off_seen_ff <= !off_seen_ff;
      if (off_seen_ff) sm_ff <= 4'(`SMOKE_HALVES); // RULE17
    end else if (half_ff && sm_ff != 4'h0) begin
      sm_ff <= sm_ff - 4'h1;
    end
  end

  // Battery saver: fail time and restore time run on opposite levels.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_ff <= 15'h0000;
      oc_ff <= 3'h0;
      bs_ff <= 1'b1;
    end else begin
      if (!ac_s) fc_ff <= 15'h0000; // RULE22
      else if (half_ff && fc_ff != BSAVE_N) fc_ff <= fc_ff + 15'h0001;
      if (ac_s) oc_ff <= 3'h0;
      else if (half_ff && oc_ff != 3'(`RESTORE_HALVES)) oc_ff <= oc_ff + 3'h1;
      if (fc_ff == BSAVE_N) bs_ff <= 1'b0; // RULE18
      else if (oc_ff == 3'(`RESTORE_HALVES)) bs_ff <= 1'b1; // RULE19
    end
  end

  // Pick the single active function onto the relay.
  always_comb begin
    unique case (fn)
      bell_pkg::FN_TROUBLE: rout = rlat_ff;
      bell_pkg::FN_ALARM:   rout = rlat_ff || rp_ff != 2'h0;
      bell_pkg::FN_LATCH:   rout = rlat_ff;
      bell_pkg::FN_SMOKE:   rout = sm_ff != 4'h0;
      bell_pkg::FN_BSAVE:   rout = bs_ff;
      default:              rout = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_relay <= 1'b0;
    end else begin
      aux_relay <= rout; // RULE11
    end
  end

  a_fn_illegal: assert property (@(posedge core_clk) disable iff (!rst_n)
    relay_ff[2:0] > 3'h4 ##1 relay_ff[2:0] > 3'h4 |-> !aux_relay) // RULE11
    else $error("relay on with undefined function");
  a_relay_hold4: assert property (@(posedge core_clk) disable iff (!rst_n)
    fn == bell_pkg::FN_LATCH && rlat_ff && !user_67 |=> rlat_ff) // RULE13
    else $error("latched relay released early");
  a_relay_off1: assert property (@(posedge core_clk) disable iff (!rst_n)
    fn == bell_pkg::FN_ALARM && rlat_ff && user_off && !rnew
    |=> !rlat_ff) // RULE12
    else $error("relay ignored OFF");
  a_smoke_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    fn == bell_pkg::FN_SMOKE && user_off && off_seen_ff
    |=> sm_ff == 4'(`SMOKE_HALVES)) // RULE17
    else $error("smoke reset pulse not started");
  a_bsave_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
    fc_ff == BSAVE_N && fn == bell_pkg::FN_BSAVE
    |=> !bs_ff ##1 !aux_relay) // RULE18
    else $error("battery saver kept relay on");

  // AXI4-Lite: ready flags double as empty flags of one-deep slots.
  logic [9:0]  aw_ix_ff;
  logic [31:0] wd_ff;
  logic [3:0]  ws_ff;
  logic        do_wr;
  logic [9:0]  ar_ix;
  logic [31:0] rd_val;
  logic        rd_err;
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ar_ix = s_axi_araddr[11:2];

  // Write channels and response.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_ix_ff      <= 10'h000;
      wd_ff         <= 32'h0000_0000;
      ws_ff         <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_ix_ff      <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wd_ff        <= s_axi_wdata;
        ws_ff        <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_ix_ff > `OFF_STATUS ? 2'h2 : 2'h0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register file; reset values give the factory defaults.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bell_cfg_ff <= `RST_BELL_CFG; // RULE5 RULE6
      bell_tmo_ff <= `RST_BELL_TMO; // RULE5 RULE6
      zones_ff    <= `RST_ZONES; // RULE5 RULE6
      sup_ff      <= `RST_SUP; // RULE1
      relay_ff    <= `RST_RELAY; // RULE14
    end else if (do_wr) begin
      unique case (aw_ix_ff)
        `OFF_BELL_CFG:
          bell_cfg_ff <= merge(bell_cfg_ff, wd_ff, ws_ff, `MSK_BELL_CFG);
        `OFF_BELL_TMO:
          bell_tmo_ff <= merge(bell_tmo_ff, wd_ff, ws_ff, `MSK_BELL_TMO);
        `OFF_ZONES: zones_ff <= merge(zones_ff, wd_ff, ws_ff, `MSK_ZONES);
        `OFF_SUP:   sup_ff <= merge(sup_ff, wd_ff, ws_ff, `MSK_SUP);
        `OFF_RELAY: relay_ff <= merge(relay_ff, wd_ff, ws_ff, `MSK_RELAY);
        default: ;
      endcase
    end
  end

  // Read decode; unmapped words read zero with a slave error.
  always_comb begin
    rd_err = 1'b0;
    unique case (ar_ix)
      `OFF_BELL_CFG: rd_val = bell_cfg_ff;
      `OFF_BELL_TMO: rd_val = bell_tmo_ff;
      `OFF_ZONES:    rd_val = zones_ff;
      `OFF_SUP:      rd_val = sup_ff;
      `OFF_RELAY:    rd_val = relay_ff;
      `OFF_STATUS:   rd_val = {17'h00000, fault_s[1], 1'b0, fault_s[0],
                               ac_s, bell_tamper, fire_silenced, trb_w,
                               aux_relay, drv_w};
      default: begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  // Read channel.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_err ? 2'h2 : 2'h0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* bell_relay_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by bell_relay_ctrl.sv only.
// Notes:   Times are kept in their own unit and converted below.
`ifndef BELL_RELAY_PARAMS_SVH
`define BELL_RELAY_PARAMS_SVH

// Clock rate and the half-second base tick.
`define CLK_HZ 40000000
`define HALF_MS 500
`define HALF_CYC (`CLK_HZ / 1000 * `HALF_MS)
`define MIN_HALVES (60 * 1000 / `HALF_MS)
`define DING_MS 1500
`define DING_HALVES (`DING_MS / `HALF_MS)
`define CHIME_MS 500
`define CHIME_HALVES (`CHIME_MS / `HALF_MS)
`define SMOKE_S 6
`define SMOKE_HALVES (`SMOKE_S * 1000 / `HALF_MS)
`define BSAVE_S 14400
`define BSAVE_HALVES (`BSAVE_S * 1000 / `HALF_MS)
`define RESTORE_S 2
`define RESTORE_HALVES (`RESTORE_S * 1000 / `HALF_MS)
`define TMO_MIN 5'h02
`define TMO_MAX 5'h1e

// Supervision zone response codes.
`define SUP_CODE 8'h13
`define SUP_NONE 8'h00

// Register word indices (byte address bits 11:2).
`define OFF_BELL_CFG 10'h000
`define OFF_BELL_TMO 10'h001
`define OFF_ZONES 10'h002
`define OFF_SUP 10'h003
`define OFF_RELAY 10'h004
`define OFF_STATUS 10'h005

// Field positions.
`define BC_PULSE 0
`define BC_DING 1
`define BC_CHIME 2
`define BC_TEMPORAL 8
`define BC_TAMPER 9
`define RC_DING 3
`define RC_CHIME 4

// Reset values and writable masks.
`define RST_BELL_CFG 32'h0000_0010
`define RST_BELL_TMO 32'h0000_0010
`define RST_ZONES 32'h0000_03fc
`define RST_SUP 32'h0000_1300
`define RST_RELAY 32'h00ff_0001
`define MSK_BELL_CFG 32'h0000_0377
`define MSK_BELL_TMO 32'h0000_1f1f
`define MSK_ZONES 32'h0000_ffff
`define MSK_SUP 32'h0000_ffff
`define MSK_RELAY 32'h00ff_1f1f

`endif

/* bell_pkg.sv */
// Purpose: Types shared by the bell and relay controller.
// Assumes: Nothing.
// Notes:   Relay function codes follow the programmed values.
package bell_pkg;

  // One supervised loop's wiring fault flags.
  typedef struct packed {
    logic open_f;
    logic shorted_f;
    logic ground_f;
  } wire_fault_s;

  // Relay function codes.
  typedef enum logic [2:0] {
    FN_TROUBLE = 3'h0,
    FN_ALARM   = 3'h1,
    FN_SMOKE   = 3'h2,
    FN_BSAVE   = 3'h3,
    FN_LATCH   = 3'h4
  } relay_fn_e;

endpackage

/* appliance_loads.sv */
// Purpose: Bell loop and relay load model for the controller bench.
// Assumes: Wiring faults are commanded by the bench, one flag per condition.
// Notes:   A broken loop reads as faulty whether or not the bell is driven.
`timescale 1ns/1ps
`default_nettype none

module appliance_loads (
  // Drive from the controller.
  input  wire logic                  [1:0] bell_on,
  input  wire logic                        relay_on,
  // Commanded faults, bell 1 in the low three bits.
  input  wire logic                  [5:0] fault_cmd,
  // Loop sense lines back to the controller.
  output var  bell_pkg::wire_fault_s [1:0] loop_fault
);
  // Faults are wiring states, so they ignore the drive level.
  always_comb begin
    loop_fault = fault_cmd;
  end
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the bell and relay controller.
// Assumes: Tick of four cycles and a ten-tick battery interval.
// Notes:   Register rows first, then hand-written panel cases.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, user_off = 0;
  logic        user_67 = 0, ac_fail = 0, fire_alarm = 0, j1 = 0, j2 = 1;
  logic        system_armed = 0, chime_fault = 0, chime_mode = 0, tr = 0;
  logic [7:0]  zone_alarm = 0;
  logic [5:0]  fault_cmd = 0;
  logic [1:0]  rr, s_axi_bresp, s_axi_rresp, bell_drive, bell_trouble;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, fire_silenced, bell_tamper, aux_relay;
  bell_pkg::wire_fault_s [1:0] bell_fault;
  int          err_count = 0, n_checks = 0, hi;
  logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h018};
  logic [31:0] rv [6] = '{32'h10, 32'h10, 32'h3fc, 32'h1300, 32'hff0001, 0};
  logic [1:0]  rp [6] = '{0, 0, 0, 0, 0, 2'h2};

  bell_relay_ctrl #(.HALF_CYCLES(4), .BSAVE_HALVES(10)) dut (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .zone_alarm, .user_off, .user_67,
    .system_armed, .chime_fault, .chime_mode,
    .fire_alarm, .trouble_any(tr), .fire_supervisory(1'b0), .ac_fail,
    .first_bell_supervision_jumper(j1), .second_bell_supervision_jumper(j2),
    .bell_fault, .bell_drive, .bell_trouble, .fire_silenced, .bell_tamper,
    .aux_relay);
  appliance_loads loads (.bell_on(bell_drive), .relay_on(aux_relay),
    .fault_cmd, .loop_fault(bell_fault));

  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wrap_up;
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A handshake that never completes ends the run at once.
  task automatic give_up(input logic ok);
    if (!ok) begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic pulse(input logic is_67);
    if (is_67) user_67 <= 1;
    else user_off <= 1;
    cyc(1);
    user_67 <= 0;
    user_off <= 0;
    cyc(3);
  endtask

  // Address and data go up together and each drops once it is taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      cyc(1);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    chk("bresp", {a > 12'h014, 1'b0}, s_axi_bresp);
    give_up(s_axi_bvalid === 1'b1);
  endtask

  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      cyc(1);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    give_up(s_axi_rvalid === 1'b1);
  endtask

  // Main sequence; relay expectations follow the short tick counts.
  initial begin
    cyc(16);
    rst_n <= 1;
    cyc(2);
    for (int i = 0; i < 6; i++) begin
      rdr(ra[i]);
      chk("reg", rv[i], rd);
      chk("resp", rp[i], rr);
    end
    wr(12'h018, 32'h0000_0000);
    zone_alarm <= 8'h04;
    cyc(4);
    chk("bell1", bell_drive[0] === 1'b1 && bell_drive[1] === 1'b0, 1);
    chk("relay", 1, aux_relay);
    zone_alarm <= 8'h01;
    pulse(0);
    chk("bell1 off", 0, bell_drive[0]);
    hi = 0;
    repeat (16) begin
      cyc(1);
      hi += bell_drive[1];
    end
    chk("pulsed", 8, hi);
    zone_alarm <= 0;
    pulse(0);
    chk("relay off", 0, aux_relay);
    for (int k = 0; k < 3; k++) begin
      fault_cmd <= 6'h09 << k;
      cyc(6);
      chk("trouble", 2'h2, bell_trouble);
    end
    fault_cmd <= 0;
    fire_alarm <= 1;
    cyc(4);
    chk("silenced", 0, fire_silenced);
    wr(12'h008, 32'h0000_00fc);
    zone_alarm <= 8'h01;
    cyc(4);
    chk("silenced", 1, fire_silenced);
    chk("no zones", 0, bell_drive[1]);
    zone_alarm <= 0;
    fire_alarm <= 0;
    pulse(0);
    wr(12'h010, 32'h00ff_0004);
    zone_alarm <= 8'h02;
    cyc(1);
    zone_alarm <= 0;
    pulse(0);
    chk("latch", 1, aux_relay);
    pulse(1);
    chk("unlatch", 0, aux_relay);
    wr(12'h010, 32'h00ff_0002);
    pulse(0);
    chk("smoke", 0, aux_relay);
    pulse(0);
    chk("smoke", 1, aux_relay);
    cyc(56);
    chk("smoke", 0, aux_relay);
    wr(12'h010, 32'h00ff_0003);
    ac_fail <= 1;
    cyc(20);
    ac_fail <= 0;
    cyc(3);
    ac_fail <= 1;
    cyc(30);
    chk("saver", 1, aux_relay);
    cyc(20);
    chk("saver", 0, aux_relay);
    ac_fail <= 0;
    cyc(30);
    chk("saver", 1, aux_relay);
    rst_n <= 0;
    cyc(2);
    chk("reset", 0, aux_relay);
    rst_n <= 1;
    rdr(12'h010);
    chk("reset reg", 32'h00ff_0001, rd);
    wr(12'h000, 32'h0000_0210);
    zone_alarm <= 8'h20;
    cyc(4);
    chk("tamper", 4, {bell_tamper, aux_relay, bell_drive[0]});
    zone_alarm <= 0;
    wr(12'h010, 32'h00ff_0009);
    wr(12'h000, 32'h0000_0042);
    system_armed <= 1;
    cyc(1);
    system_armed <= 0;
    cyc(3);
    chk("ding", 3, {aux_relay, bell_drive[0]});
    cyc(16);
    chk("ding", 0, {aux_relay, bell_drive[0]});
    for (int m = 0; m < 2; m++) begin
      chime_mode <= m[0];
      chime_fault <= 1;
      cyc(1);
      chime_fault <= 0;
      cyc(2);
      chk("chime", m, {aux_relay, bell_drive[1]});
      cyc(8);
    end
    wr(12'h010, 32'h00ff_0000);
    tr <= 1;
    pulse(0);
    chk("trbl", 1, aux_relay);
    tr <= 0;
    pulse(0);
    chk("trbl", 0, aux_relay);
    wr(12'h004, 32'h0000_0001);
    zone_alarm <= 8'h04;
    cyc(900);
    chk("tmo", 1, bell_drive[0]);
    cyc(70);
    chk("tmo", 0, bell_drive[0]);
    wrap_up();
  end
endmodule
`default_nettype wire
